// file: dv/scb_config_bank_bench.sv
// self-checking bench for the strap configuration register bank
// assumes the host model drives the register port; straps and select driven here
module scb_config_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock, rst_n, mode, lvl_a, lvl_b, host_wr_valid, det_a_o, det_b_o;
  logic        host_access_enabled, host_wr_refused, config_captured;
  logic [25:0] sv;
  logic [1:0]  host_wr_sel, host_rd_sel;
  logic [7:0]  host_wr_data, host_rd_data, ga_o, gb_o;
  logic [6:0]  c7;
  logic [2:0]  addr_o;
  int          err_count = 0;
  int          n_checks  = 0;
  int          cyc       = 0;
  int          m_reg[4];  // reference: ctrl, group A, group B, address

  // ----------------------------------------------------------------
  // clock, design and host
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  scb_config_bank DUT (
    .clock(clock), .rst_n(rst_n),
    .loopback_n(sv[0]), .chan_reset_n(sv[1]), .power_down_n(sv[2]),
    .group_a_rx_detect_en(sv[3]), .group_b_rx_detect_en(sv[4]),
    .group_a_emph_type_select(sv[5]), .group_b_emph_type_select(sv[6]),
    .group_a_eq_select(sv[9:7]), .group_a_emph_level(sv[12:10]),
    .group_a_swing_select(sv[14:13]), .group_b_eq_select(sv[17:15]),
    .group_b_emph_level(sv[20:18]), .group_b_swing_select(sv[22:21]),
    .slave_address_straps(sv[25:23]), .config_source_select(mode),
    .group_a_level_above_threshold(lvl_a), .group_b_level_above_threshold(lvl_b),
    .host_wr_valid(host_wr_valid), .host_wr_sel(host_wr_sel),
    .host_wr_data(host_wr_data), .host_rd_sel(host_rd_sel),
    .host_rd_data(host_rd_data), .host_access_enabled(host_access_enabled),
    .host_wr_refused(host_wr_refused), .config_captured(config_captured),
    .cfg_loopback_n(c7[0]), .cfg_chan_reset_n(c7[1]), .cfg_power_down_n(c7[2]),
    .cfg_group_a_rx_detect_en(c7[3]), .cfg_group_b_rx_detect_en(c7[4]),
    .cfg_group_a_emph_type(c7[5]), .cfg_group_b_emph_type(c7[6]),
    .cfg_group_a_eq_level(ga_o[2:0]), .cfg_group_b_eq_level(gb_o[2:0]),
    .cfg_group_a_emph_level(ga_o[5:3]), .cfg_group_b_emph_level(gb_o[5:3]),
    .cfg_group_a_swing(ga_o[7:6]), .cfg_group_b_swing(gb_o[7:6]),
    .slave_address_bits(addr_o), .group_a_signal_detected(det_a_o),
    .group_b_signal_detected(det_b_o)
  );

  scb_host_model host (
    .clock(clock), .host_wr_valid(host_wr_valid), .host_wr_sel(host_wr_sel),
    .host_wr_data(host_wr_data), .host_rd_sel(host_rd_sel),
    .host_rd_data(host_rd_data), .host_wr_refused(host_wr_refused)
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // applied outputs and every readable register against the reference
  task automatic chk_all();
    logic [7:0] d;
    chk({1'b0, c7}, 8'(m_reg[0]));
    chk(ga_o, 8'(m_reg[1]));
    chk(gb_o, 8'(m_reg[2]));
    chk({5'h00, addr_o}, 8'(m_reg[3]));
    for (int i = 0; i < 4; i++) begin
      host.rd(2'(i), d);
      chk(d, 8'(m_reg[i]));
    end
  endtask : chk_all

  // power-on with fresh random straps, strap control selected
  task automatic do_reset();
    sv    = 26'($urandom());
    rst_n = 1'b0;
    mode  = 1'b1;
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    for (int s = 0; s < 10 && config_captured !== 1'b1; s++) @(negedge clock);
    chk({7'h00, config_captured}, 8'h01);
    m_reg = '{int'(sv[6:0]), int'(sv[14:7]), int'(sv[22:15]), int'(sv[25:23])};
    chk_all();
  endtask : do_reset

  // hang guard, under two hundred cycles are expected
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    logic       r;
    int         sel;
    logic [7:0] d;
    void'($urandom(32'h30E7));
    {lvl_a, lvl_b} = 2'h0;
    do_reset();
    chk({7'h00, host_access_enabled}, 8'h00);
    // straps move after capture: nothing may follow them
    sv = ~sv;
    repeat (6) @(negedge clock);
    chk_all();
    // strap control: every write refused, state kept
    for (int i = 0; i < 3; i++) begin
      host.wr(2'(i), 8'($urandom()), 1'b0, r);
      chk({7'h00, r}, 8'h01);
    end
    host.idle();
    chk_all();
    // select dropped: access opens after the sync latency, never latched
    mode = 1'b0;
    repeat (2) @(negedge clock);
    chk({7'h00, host_access_enabled}, 8'h00);
    @(negedge clock);
    chk({7'h00, host_access_enabled}, 8'h01);
    // random writes, back to back or with gaps
    for (int i = 0; i < 24; i++) begin
      sel = $urandom_range(2, 0);
      d   = 8'($urandom());
      host.wr(2'(sel), d, 1'($urandom()), r);
      chk({7'h00, r}, 8'h00);
      m_reg[sel] = (sel == 0) ? int'(d & 8'h7F) : int'(d);
    end
    // every equalization code on both groups
    for (int k = 0; k < 8; k++) begin
      d = 8'($urandom());
      host.wr(2'h1, {d[7:3], 3'(k)}, 1'b0, r);
      host.wr(2'h2, {d[7:3], 3'(7 - k)}, 1'b0, r);
      m_reg[1] = int'({d[7:3], 3'(k)});
      m_reg[2] = int'({d[7:3], 3'(7 - k)});
      chk({5'h00, ga_o[2:0]}, 8'(k));
      chk({5'h00, gb_o[2:0]}, 8'(7 - k));
    end
    host.wr(2'h3, 8'hFF, 1'b0, r);
    host.idle();
    chk_all();
    // select raised mid-run closes access again
    mode = 1'b1;
    repeat (3) @(negedge clock);
    host.wr(2'h1, 8'h00, 1'b0, r);
    host.idle();
    chk({7'h00, r}, 8'h01);
    chk_all();
    // detector inputs follow with three edges of latency
    for (int i = 0; i < 8; i++) begin
      {lvl_a, lvl_b} = 2'($urandom());
      repeat (3) @(negedge clock);
      chk({6'h00, det_a_o, det_b_o}, {6'h00, lvl_a, lvl_b});
    end
    // second power-on recaptures new straps
    do_reset();
    stop_test();
  end
endmodule : scb_config_bank_bench

// file: dv/scb_host_model.sv
// host side model: drives the register write and read port as a two-wire host would
// assumes the bank samples its port on the rising edge and tasks start at a falling edge
module scb_host_model (
  input  wire logic       clock,
  output logic            host_wr_valid,
  output logic      [1:0] host_wr_sel,
  output logic      [7:0] host_wr_data,
  output logic      [1:0] host_rd_sel,
  input  wire logic [7:0] host_rd_data,
  input  wire logic       host_wr_refused
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // port tasks
  // ----------------------------------------------------------------
  // quiet port at time zero
  initial begin
    host_wr_valid = 1'b0;
    host_wr_sel   = 2'h0;
    host_wr_data  = 8'hA5;
    host_rd_sel   = 2'h0;
  end

  // one write; valid stays up so writes can run back to back, slow inserts a gap
  task automatic wr(input logic [1:0] sel, input logic [7:0] data, input bit slow,
                    output logic refused);
    if (slow) begin
      host_wr_valid = 1'b0;
      @(negedge clock);
    end
    host_wr_valid = 1'b1;
    host_wr_sel   = sel;
    host_wr_data  = data;
    @(negedge clock);
    refused = host_wr_refused;
  endtask : wr

  // release the write lines; data no longer holds its last value
  task automatic idle();
    host_wr_valid = 1'b0;
    host_wr_data  = ~host_wr_data;
  endtask : idle

  // register read with one cycle of latency, select 3 gives the address straps
  task automatic rd(input logic [1:0] sel, output logic [7:0] data);
    host_rd_sel = sel;
    @(negedge clock);
    data = host_rd_data;
  endtask : rd
endmodule : scb_host_model

// file: src/scb_config_bank.sv
// strap configuration register bank: strap capture, host write gating, group settings
// assumes host write and read port signals are on clock; all pins are asynchronous
module scb_config_bank (
  input  wire logic       clock,
  input  wire logic       rst_n,
  // strap pins
  input  wire logic       loopback_n,
  input  wire logic       chan_reset_n,
  input  wire logic       power_down_n,
  input  wire logic       group_a_rx_detect_en,
  input  wire logic       group_b_rx_detect_en,
  input  wire logic       group_a_emph_type_select,
  input  wire logic       group_b_emph_type_select,
  input  wire logic [2:0] group_a_eq_select,
  input  wire logic [2:0] group_b_eq_select,
  input  wire logic [2:0] group_a_emph_level,
  input  wire logic [2:0] group_b_emph_level,
  input  wire logic [1:0] group_a_swing_select,
  input  wire logic [1:0] group_b_swing_select,
  input  wire logic [2:0] slave_address_straps,
  input  wire logic       config_source_select,
  input  wire logic       group_a_level_above_threshold,
  input  wire logic       group_b_level_above_threshold,
  // host register port
  input  wire logic       host_wr_valid,
  input  wire logic [1:0] host_wr_sel,
  input  wire logic [7:0] host_wr_data,
  input  wire logic [1:0] host_rd_sel,
  output logic      [7:0] host_rd_data,
  output logic            host_access_enabled,
  output logic            host_wr_refused,
  output logic            config_captured,
  // applied configuration
  output logic            cfg_loopback_n,
  output logic            cfg_chan_reset_n,
  output logic            cfg_power_down_n,
  output logic            cfg_group_a_rx_detect_en,
  output logic            cfg_group_b_rx_detect_en,
  output logic            cfg_group_a_emph_type,
  output logic            cfg_group_b_emph_type,
  output logic      [2:0] cfg_group_a_eq_level,
  output logic      [2:0] cfg_group_b_eq_level,
  output logic      [2:0] cfg_group_a_emph_level,
  output logic      [2:0] cfg_group_b_emph_level,
  output logic      [1:0] cfg_group_a_swing,
  output logic      [1:0] cfg_group_b_swing,
  output logic      [2:0] slave_address_bits,
  output logic            group_a_signal_detected,
  output logic            group_b_signal_detected
);

  scb_strap_if pins ();

  logic [scb_pkg::STRAP_WIDTH-1:0] straps_raw;
  logic [7:0]                      ctrl_q;
  logic [7:0]                      grp_a_q;
  logic [7:0]                      grp_b_q;
  logic [2:0]                      addr_q;
  logic                            captured_q;
  logic                            access_q;
  logic                            refused_q;
  logic [7:0]                      rd_q;
  logic                            det_a_q;
  logic                            det_b_q;
  logic                            wr_ok;

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  // true when an accepted host write targets register idx
  function automatic logic wr_hits(input logic ok, input logic [1:0] sel, input logic [1:0] idx);
    wr_hits = ok && (sel == idx);
  endfunction : wr_hits

  // pack one group's straps in register field order
  function automatic logic [7:0] grp_pack(input logic [2:0] eq, input logic [2:0] emph,
                                          input logic [1:0] swing);
    grp_pack = {swing, emph, eq};
  endfunction : grp_pack

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  // strap vector in the layout that the capture logic slices
  assign straps_raw = {slave_address_straps,                                      // RL16
                       grp_pack(group_b_eq_select, group_b_emph_level,            // RL14
                                group_b_swing_select),
                       grp_pack(group_a_eq_select, group_a_emph_level,
                                group_a_swing_select),                            // RL2
                       group_b_emph_type_select, group_a_emph_type_select,
                       group_b_rx_detect_en, group_a_rx_detect_en,                // RL1
                       power_down_n, chan_reset_n, loopback_n};

  scb_pin_sync u_sync (
    .clock      (clock),
    .rst_n      (rst_n),
    .straps_raw (straps_raw),
    .mode_raw   (config_source_select),
    .det_a_raw  (group_a_level_above_threshold),
    .det_b_raw  (group_b_level_above_threshold),
    .pins       (pins)
  );

  // source select read live every cycle, never held
  assign wr_ok = host_wr_valid && captured_q && !pins.mode_high;    // RL5 RL6 RL7 RL15

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // capture beats a host write in its cycle; writes wait until captured
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_q  <= scb_pkg::CTRL_RST;
      grp_a_q <= scb_pkg::GRP_RST;
      grp_b_q <= scb_pkg::GRP_RST;
    end else if (pins.capture) begin
      ctrl_q  <= {1'b0, pins.straps[scb_pkg::STRAP_CTRL_LSB +: 7]};   // RL8
      grp_a_q <= pins.straps[scb_pkg::STRAP_GRP_A_LSB +: 8];           // RL11 RL13
      grp_b_q <= pins.straps[scb_pkg::STRAP_GRP_B_LSB +: 8];           // RL11 RL13 RL14
    end else begin
      if (wr_hits(wr_ok, host_wr_sel, scb_pkg::SEL_CTRL)) begin
        ctrl_q <= {1'b0, host_wr_data[6:0]};                           // RL6
      end
      if (wr_hits(wr_ok, host_wr_sel, scb_pkg::SEL_GRP_A)) begin
        grp_a_q <= host_wr_data;
      end
      if (wr_hits(wr_ok, host_wr_sel, scb_pkg::SEL_GRP_B)) begin
        grp_b_q <= host_wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // slave address and capture flag
  // ----------------------------------------------------------------
  // address bits are strap-only; the host cannot move its own address
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      addr_q     <= scb_pkg::ADDR_RST;
      captured_q <= 1'b0;
    end else if (pins.capture) begin
      addr_q     <= pins.straps[scb_pkg::STRAP_ADDR_LSB +: 3];        // RL16
      captured_q <= 1'b1;                                             // RL17
    end
  end

  // ----------------------------------------------------------------
  // host port status and read data
  // ----------------------------------------------------------------
  // refused is high the cycle after each refused write cycle; read data lags its select by one edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      access_q  <= 1'b0;
      refused_q <= 1'b0;
      rd_q      <= 8'h00;
    end else begin
      access_q  <= !pins.mode_high;                                   // RL7 RL15
      refused_q <= host_wr_valid && !wr_ok;                           // RL5
      case (host_rd_sel)
        scb_pkg::SEL_CTRL:  rd_q <= ctrl_q;
        scb_pkg::SEL_GRP_A: rd_q <= grp_a_q;
        scb_pkg::SEL_GRP_B: rd_q <= grp_b_q;
        default:            rd_q <= {5'h00, addr_q};
      endcase
    end
  end

  // ----------------------------------------------------------------
  // signal detect status
  // ----------------------------------------------------------------
  // detector levels leave the synchroniser through one more register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      det_a_q <= 1'b0;
      det_b_q <= 1'b0;
    end else begin
      det_a_q <= pins.det_a;                                          // RL3
      det_b_q <= pins.det_b;                                          // RL3
    end
  end

  // ----------------------------------------------------------------
  // outputs, each a register bit
  // ----------------------------------------------------------------
  // one field per group drives all four lanes of that group alike
  assign cfg_loopback_n           = ctrl_q[scb_pkg::CTRL_LOOPBACK_N];              // RL4
  assign cfg_chan_reset_n         = ctrl_q[scb_pkg::CTRL_CHAN_RST_N];
  assign cfg_power_down_n         = ctrl_q[scb_pkg::CTRL_PWR_DOWN_N];
  assign cfg_group_a_rx_detect_en = ctrl_q[scb_pkg::CTRL_RXD_A];
  assign cfg_group_b_rx_detect_en = ctrl_q[scb_pkg::CTRL_RXD_B];                   // RL1
  assign cfg_group_a_emph_type    = ctrl_q[scb_pkg::CTRL_EMPH_TYP_A];
  assign cfg_group_b_emph_type    = ctrl_q[scb_pkg::CTRL_EMPH_TYP_B];
  assign cfg_group_a_eq_level     = grp_a_q[scb_pkg::GRP_EQ_LSB +: 3];             // RL9 RL10
  assign cfg_group_b_eq_level     = grp_b_q[scb_pkg::GRP_EQ_LSB +: 3];             // RL9 RL10
  assign cfg_group_a_emph_level   = grp_a_q[scb_pkg::GRP_EMPH_LSB +: 3];           // RL12
  assign cfg_group_b_emph_level   = grp_b_q[scb_pkg::GRP_EMPH_LSB +: 3];           // RL12
  assign cfg_group_a_swing        = grp_a_q[scb_pkg::GRP_SWING_LSB +: 2];          // RL2
  assign cfg_group_b_swing        = grp_b_q[scb_pkg::GRP_SWING_LSB +: 2];          // RL2
  assign slave_address_bits       = addr_q;
  assign group_a_signal_detected  = det_a_q;
  assign group_b_signal_detected  = det_b_q;
  assign host_rd_data             = rd_q;
  assign host_access_enabled      = access_q;
  assign host_wr_refused          = refused_q;
  assign config_captured          = captured_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_refuse_strap_mode: assert property (   // RL5
    pins.mode_high && host_wr_valid && !pins.capture
    |=> $stable(ctrl_q) && $stable(grp_a_q) && $stable(grp_b_q) && host_wr_refused)
    else $error("write changed registers while strap mode selected");

  a_hold_strap_cfg: assert property (      // RL4
    pins.mode_high && captured_q [*3] |=> $stable(cfg_group_a_eq_level))
    else $error("strap configuration moved in strap mode");

  a_accept_host_a: assert property (       // RL6
    captured_q && !pins.mode_high && host_wr_valid && host_wr_sel == scb_pkg::SEL_GRP_A
    |=> grp_a_q == $past(host_wr_data) && !host_wr_refused)
    else $error("accepted group A write not stored");

  a_mode_live_gate: assert property (      // RL7
    $changed(pins.mode_high) |=> host_access_enabled == !$past(pins.mode_high))
    else $error("host access did not follow source select");

  a_strap_disables_host: assert property ( // RL15
    pins.mode_high |=> !host_access_enabled)
    else $error("host access enabled under strap control");

  a_capture_once: assert property (        // RL17
    pins.capture |=> !pins.capture [*8])
    else $error("straps captured more than once");

  a_capture_ctrl: assert property (        // RL8
    pins.capture |=> cfg_group_b_rx_detect_en == $past(pins.straps[4])
                     && cfg_loopback_n == $past(pins.straps[0]) && config_captured)
    else $error("control straps not captured");

  a_capture_eq_b: assert property (        // RL11
    pins.capture |=> cfg_group_b_eq_level == $past(pins.straps[17:15])
                     && cfg_group_a_eq_level == $past(pins.straps[9:7]))
    else $error("equalization straps not loaded");

  a_capture_swing: assert property (       // RL13
    pins.capture |=> cfg_group_a_swing == $past(pins.straps[14:13])
                     && cfg_group_b_emph_level == $past(pins.straps[20:18]))
    else $error("output straps not loaded");

  a_sig_detect_a: assert property (        // RL3
    ##1 group_a_signal_detected == $past(pins.det_a))
    else $error("signal detect did not follow input");

  a_sig_detect_b: assert property (        // RL3
    ##1 group_b_signal_detected == $past(pins.det_b))
    else $error("group B detect did not follow input");

  // ----------------------------------------------------------------
  // assertions on host writes, read data and remaining straps
  // ----------------------------------------------------------------
  a_accept_host_b: assert property (       // RL6
    captured_q && !pins.mode_high && host_wr_valid && host_wr_sel == scb_pkg::SEL_GRP_B
    |=> grp_b_q == $past(host_wr_data) && !host_wr_refused)
    else $error("accepted group B write not stored");

  a_accept_ctrl: assert property (         // RL6
    captured_q && !pins.mode_high && host_wr_valid && host_wr_sel == scb_pkg::SEL_CTRL
    |=> ctrl_q == {1'b0, $past(host_wr_data[6:0])})
    else $error("accepted control write not stored");

  a_read_ctrl: assert property (           // RL6
    host_rd_sel == scb_pkg::SEL_CTRL |=> host_rd_data == $past(ctrl_q))
    else $error("control read data wrong");

  a_read_addr: assert property (           // RL16
    host_rd_sel == 2'h3 |=> host_rd_data == {5'h00, $past(slave_address_bits)})
    else $error("address read data wrong");

  a_capture_addr: assert property (        // RL16
    pins.capture |=> slave_address_bits == $past(pins.straps[25:23]))
    else $error("address straps not captured");

  a_capture_out_b: assert property (       // RL2 RL13
    pins.capture |=> cfg_group_b_swing == $past(pins.straps[22:21])
                     && cfg_group_a_emph_level == $past(pins.straps[12:10]))
    else $error("group B swing straps not loaded");

  a_capture_rest: assert property (        // RL8
    pins.capture |=> cfg_power_down_n == $past(pins.straps[2])
                     && cfg_chan_reset_n == $past(pins.straps[1])
                     && cfg_group_b_emph_type == $past(pins.straps[6]))
    else $error("remaining control straps not loaded");

  // main scenarios, each to be seen at least once
  c_capture:   cover property (pins.capture);
  c_wr_accept: cover property (wr_ok ##1 !host_wr_refused);
  c_wr_refuse: cover property (host_wr_valid && pins.mode_high ##1 host_wr_refused);
  c_mode_drop: cover property (captured_q && $fell(pins.mode_high));
  c_read_addr: cover property (host_rd_sel == 2'h3 ##1 host_rd_data == {5'h00, slave_address_bits});

endmodule : scb_config_bank

// file: src/scb_pin_sync.sv
// two-stage synchronisers for all pin inputs and the one-shot strap capture pulse
// assumes pins are asynchronous to clock and rst_n is the power-on reset
module scb_pin_sync (
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  input  wire logic [scb_pkg::STRAP_WIDTH-1:0] straps_raw,
  input  wire logic                          mode_raw,
  input  wire logic                          det_a_raw,
  input  wire logic                          det_b_raw,
  scb_strap_if.sync                          pins
);

  logic [scb_pkg::STRAP_WIDTH-1:0] straps_m_q;
  logic [scb_pkg::STRAP_WIDTH-1:0] straps_s_q;
  logic [2:0]                      misc_m_q;
  logic [2:0]                      misc_s_q;
  logic [1:0]                      fill_q;
  logic                            done_q;
  logic                            capture_q;

  // ----------------------------------------------------------------
  // synchronisers: first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    straps_m_q <= straps_raw;          // RL17
    straps_s_q <= straps_m_q;
    misc_m_q   <= {mode_raw, det_b_raw, det_a_raw};
    if (!rst_n) begin
      misc_s_q <= {scb_pkg::MODE_RST, 2'h0};
    end else begin
      misc_s_q <= misc_m_q;            // RL7
    end
  end

  // ----------------------------------------------------------------
  // capture once, after the sync stages have filled
  // ----------------------------------------------------------------
  // waiting two edges avoids loading stale pipeline contents
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fill_q    <= 2'h0;
      done_q    <= 1'b0;
      capture_q <= 1'b0;
    end else begin
      capture_q <= 1'b0;
      if (fill_q != scb_pkg::SYNC_FILL) begin
        fill_q <= fill_q + 2'h1;
      end else if (!done_q) begin
        done_q    <= 1'b1;             // RL17
        capture_q <= 1'b1;
      end
    end
  end

  assign pins.straps    = straps_s_q;
  assign pins.det_a     = misc_s_q[0];
  assign pins.det_b     = misc_s_q[1];
  assign pins.mode_high = misc_s_q[2];
  assign pins.capture   = capture_q;

endmodule : scb_pin_sync

// file: src/scb_pkg.sv
// constants shared by the strap configuration register bank and its pin synchroniser
// assumes one 25 MHz clock and a synchronous active-low power-on reset
//
// Behaviour
// [RL1] one receiver-detect enable strap serves all four group B channels
// [RL2] each group takes a two-bit swing select from its own strap pair
// [RL3] group signal-detect output is high while channel 0 input exceeds threshold
// [RL4] with source select high, configuration comes from captured straps in registers
// [RL5] with source select high, every host register write is refused
// [RL6] with source select low, host writes to control registers are accepted
// [RL7] source select is never latched; it gates host access every cycle
// [RL8] all listed straps are captured into the registers once at power-on
// [RL9] one equalization setting per group, applied alike to its four channels
// [RL10] equalization is a three-bit code, 000 weakest to 111 strongest
// [RL11] each group's three equalization straps load its equalization field at power-up
// [RL12] one swing and emphasis setting per group, applied alike to its channels
// [RL13] swing and emphasis-level straps load the output fields at power-up
// [RL14] group B has its own three equalization select straps
// [RL15] source select high means strap control and no host operation; host reads still return register data here
// [RL16] three straps give slave address bits 0, 1 and 4
// [RL17] straps are synchronised and captured exactly once after reset release
package scb_pkg;

  // ----------------------------------------------------------------
  // register selects for the host write and read port
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_CTRL  = 2'h0;
  localparam logic [1:0] SEL_GRP_A = 2'h1;
  localparam logic [1:0] SEL_GRP_B = 2'h2;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_LOOPBACK_N = 0;
  localparam int CTRL_CHAN_RST_N = 1;
  localparam int CTRL_PWR_DOWN_N = 2;
  localparam int CTRL_RXD_A      = 3;
  localparam int CTRL_RXD_B      = 4;
  localparam int CTRL_EMPH_TYP_A = 5;
  localparam int CTRL_EMPH_TYP_B = 6;

  // ----------------------------------------------------------------
  // group register fields: eq [2:0], emphasis [5:3], swing [7:6]
  // ----------------------------------------------------------------
  localparam int GRP_EQ_LSB    = 0;
  localparam int GRP_EMPH_LSB  = 3;
  localparam int GRP_SWING_LSB = 6;

  // ----------------------------------------------------------------
  // synchronised strap vector layout
  // ----------------------------------------------------------------
  localparam int STRAP_CTRL_LSB  = 0;   // 7 control bits
  localparam int STRAP_GRP_A_LSB = 7;   // 8 group A bits
  localparam int STRAP_GRP_B_LSB = 15;  // 8 group B bits
  localparam int STRAP_ADDR_LSB  = 23;  // 3 address bits
  localparam int STRAP_WIDTH     = 26;

  // ----------------------------------------------------------------
  // values after reset: strap pins are pulled up, so ones
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST   = 8'h7F;
  localparam logic [7:0] GRP_RST    = 8'hFF;
  localparam logic [2:0] ADDR_RST   = 3'h7;
  localparam logic       MODE_RST   = 1'b1;
  localparam logic [1:0] SYNC_FILL  = 2'h2;  // edges until sync stages hold pin values

endpackage : scb_pkg

// file: src/scb_strap_if.sv
// carrier for synchronised pins between the pin synchroniser and the register bank
// assumes both ends run on the same clock
interface scb_strap_if;
  logic [25:0] straps;
  logic        mode_high;
  logic        det_a;
  logic        det_b;
  logic        capture;

  modport sync (output straps, output mode_high, output det_a, output det_b, output capture);
  modport bank (input straps, input mode_high, input det_a, input det_b, input capture);
endinterface : scb_strap_if
